// File: hdl/level_sync.sv
// Two-flop synchroniser for the thresholded enable level
`timescale 1ns/1ps
module level_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  logic meta;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// File: hdl/rail_seq_pkg.sv
// Shared constants and types for the three-rail power sequencer
package rail_seq_pkg;
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned TICK_US       = 1;
  localparam int unsigned TICK_CYCLES   = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned MS_TICKS      = 1000 / TICK_US;
  localparam int unsigned REFRESH_US    = 400;
  localparam int unsigned REFRESH_TICKS = REFRESH_US / TICK_US;
  localparam int unsigned SETTLE_MS     = 120;
  localparam int unsigned SETTLE_TICKS  = SETTLE_MS * MS_TICKS;
  localparam int unsigned STEP_BASE_MS  = 2;
  localparam int unsigned TWIDTH        = 20;
  localparam int unsigned AV_ADDR_W     = 4;

  // Register byte addresses
  localparam logic [AV_ADDR_W-1:0] REG_UP_DELAYS   = 4'h0;
  localparam logic [AV_ADDR_W-1:0] REG_DOWN_DELAYS = 4'h4;
  localparam logic [AV_ADDR_W-1:0] REG_CONFIG      = 4'h8;
  localparam logic [AV_ADDR_W-1:0] REG_STATUS      = 4'hC;

  // Field positions
  localparam int unsigned F_D1 = 0;
  localparam int unsigned F_D2 = 4;
  localparam int unsigned F_D3 = 8;
  localparam int unsigned F_COL   = 0;
  localparam int unsigned F_ORDER = 4;

  localparam logic [3:0]  RST_DELAY = 4'hF;
  localparam logic [1:0]  RST_COL   = 2'h3;
  localparam logic [2:0]  RST_ORDER = 3'h0;

  typedef enum logic [3:0] {
    ST_OFF     = 4'h0,
    ST_UP1     = 4'h1,
    ST_UP2     = 4'h2,
    ST_UP3     = 4'h3,
    ST_ON      = 4'h4,
    ST_SETTLE  = 4'h5,
    ST_DN1     = 4'h6,
    ST_DN2     = 4'h7,
    ST_DN3     = 4'h8
  } seq_state_t;

  typedef struct packed {
    logic        write;
    logic        read;
    logic [AV_ADDR_W-1:0] address;
    logic [31:0] writedata;
  } av_req_t;

  typedef struct packed {
    logic [3:0] d1;
    logic [3:0] d2;
    logic [3:0] d3;
  } delay_set_t;
endpackage

// File: hdl/rail_sequencer.sv
// Three-rail power sequencer with Avalon-MM configuration port
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module rail_sequencer
  import rail_seq_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 seq_enable,
  input  wire logic [AV_ADDR_W-1:0] avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  output logic                      rail_release_first,
  output logic                      rail_release_second,
  output logic                      rail_release_third,
  output logic                      rail_oe_first,
  output logic                      rail_oe_second,
  output logic                      rail_oe_third
);
  logic       tick;
  logic       en_s;
  logic       en_d;
  av_req_t    req;

  tick_divider #(.DIV(TICK_DIV)) u_tick (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .tick     (tick)
  );

  level_sync u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      (seq_enable),
    .dout     (en_s)
  );

  assign req = '{write: avs_write, read: avs_read, address: avs_address, writedata: avs_writedata};

  // Configuration registers
  delay_set_t up_dly, dn_dly, next_up_dly, next_dn_dly;
  logic [1:0] col, next_col;
  logic [2:0] order, next_order;
  logic       ack, next_ack;
  logic [31:0] next_rdata;
  seq_state_t state, next_state;
  logic [2:0] rails, next_rails;

  always_comb begin
    next_up_dly = up_dly;
    next_dn_dly = dn_dly;
    next_col    = col;
    next_order  = order;
    next_rdata  = avs_readdata;
    next_ack    = 1'b0;
    if ((req.read || req.write) && !ack) begin
      next_ack = 1'b1;
      if (req.read) begin
        unique case (req.address)
          REG_UP_DELAYS:   next_rdata = {20'h00000, up_dly.d3, up_dly.d2, up_dly.d1};
          REG_DOWN_DELAYS: next_rdata = {20'h00000, dn_dly.d3, dn_dly.d2, dn_dly.d1};
          REG_CONFIG:      next_rdata = {25'h0000000, order, 2'h0, col};
          REG_STATUS:      next_rdata = {24'h000000, en_s, state, rails};
          default:         next_rdata = '0;
        endcase
      end else begin
        next_rdata = '0;
      end
    end
    // A write lands only at the edge where waitrequest is seen low
    if (req.write && ack) begin
      unique case (req.address)
        REG_UP_DELAYS: next_up_dly = '{d1: req.writedata[F_D1+:4], d2: req.writedata[F_D2+:4],
                                       d3: req.writedata[F_D3+:4]};
        REG_DOWN_DELAYS: next_dn_dly = '{d1: req.writedata[F_D1+:4], d2: req.writedata[F_D2+:4],
                                         d3: req.writedata[F_D3+:4]};
        REG_CONFIG: begin
          next_col = req.writedata[F_COL+:2];
          if (req.writedata[F_ORDER+:3] <= 3'h5) begin
            next_order = req.writedata[F_ORDER+:3];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      up_dly       <= '{d1: RST_DELAY, d2: RST_DELAY, d3: RST_DELAY};
      dn_dly       <= '{d1: RST_DELAY, d2: RST_DELAY, d3: RST_DELAY};
      col          <= RST_COL;
      order        <= RST_ORDER;
      ack          <= 1'b0;
      avs_readdata <= '0;
      avs_waitrequest <= 1'b1;
    end else begin
      up_dly       <= next_up_dly;
      dn_dly       <= next_dn_dly;
      col          <= next_col;
      order        <= next_order;
      ack          <= next_ack;
      avs_readdata <= next_rdata;
      avs_waitrequest <= !next_ack;
    end
  end

  // Sequencer
  logic [TWIDTH-1:0] remain, next_remain;
  logic              pend_off, next_pend_off;
  logic [3:0]        step_ms;

  // Step size per column in ms
  assign step_ms = 4'(STEP_BASE_MS) * ({2'h0, col} + 4'h1);

  function automatic logic [TWIDTH-1:0] dly_ticks(input logic [3:0] code, input logic [3:0] stp);
    dly_ticks = TWIDTH'(code * stp * MS_TICKS);
  endfunction

  // Index (0..2) of the rail lowered at power-down step k
  function automatic logic [1:0] down_rail(input logic [2:0] ord, input logic [1:0] k);
    logic [5:0] seqv;
    seqv = 6'h00;
    unique case (ord)
      3'h0: seqv = {2'd0, 2'd1, 2'd2};
      3'h1: seqv = {2'd1, 2'd0, 2'd2};
      3'h2: seqv = {2'd0, 2'd2, 2'd1};
      3'h3: seqv = {2'd2, 2'd0, 2'd1};
      3'h4: seqv = {2'd1, 2'd2, 2'd0};
      default: seqv = {2'd2, 2'd1, 2'd0};
    endcase
    down_rail = seqv[2*k+:2];
  endfunction

  logic en_rise, en_fall, expired;
  assign en_rise = en_s && !en_d;
  assign en_fall = !en_s && en_d;
  assign expired = (remain == '0);

  always_comb begin
    next_state    = state;
    next_rails    = rails;
    next_remain   = remain;
    next_pend_off = pend_off;
    if (tick && !expired) begin
      next_remain = remain - TWIDTH'(1);
    end
    unique case (state)
      ST_OFF: begin
        next_pend_off = 1'b0;
        if (en_s) begin
          next_state  = ST_UP1;
          next_remain = dly_ticks(up_dly.d1, step_ms) + TWIDTH'(REFRESH_TICKS);
        end
      end
      ST_UP1: begin
        if (!en_s) begin
          next_state = ST_OFF;
        end else if (expired) begin
          next_rails[0] = 1'b1;
          next_state    = ST_UP2;
          next_remain   = dly_ticks(up_dly.d2, step_ms);
        end
      end
      ST_UP2, ST_UP3: begin
        if (en_fall) begin
          next_pend_off = 1'b1;
          next_remain   = dly_ticks(state == ST_UP2 ? up_dly.d2 : up_dly.d3, step_ms);
        end else if (expired) begin
          if (state == ST_UP2) begin
            next_rails[1] = 1'b1;
            next_state    = ST_UP3;
            next_remain   = dly_ticks(up_dly.d3, step_ms);
          end else begin
            next_rails[2] = 1'b1;
            if (pend_off || !en_s) begin
              next_state  = ST_SETTLE;
              next_remain = TWIDTH'(SETTLE_TICKS);
            end else begin
              next_state = ST_ON;
            end
          end
        end
      end
      ST_ON: begin
        if (!en_s) begin
          next_state  = ST_DN1;
          next_remain = dly_ticks(dn_dly.d1, step_ms) + TWIDTH'(REFRESH_TICKS);
        end
      end
      ST_SETTLE: begin
        if (expired) begin
          next_state  = ST_DN1;
          next_remain = dly_ticks(dn_dly.d1, step_ms) + TWIDTH'(REFRESH_TICKS);
        end
      end
      ST_DN1, ST_DN2, ST_DN3: begin
        if (expired) begin
          if (state == ST_DN1) begin
            next_rails[down_rail(order, 2'd0)] = 1'b0;
            next_state  = ST_DN2;
            next_remain = dly_ticks(dn_dly.d2, step_ms);
          end else if (state == ST_DN2) begin
            next_rails[down_rail(order, 2'd1)] = 1'b0;
            next_state  = ST_DN3;
            next_remain = dly_ticks(dn_dly.d3, step_ms);
          end else begin
            next_rails = 3'b000;
            next_state = ST_OFF;
          end
        end
      end
      default: begin
        next_state = ST_OFF;
        next_rails = 3'b000;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_OFF;
      rails    <= 3'b000;
      remain   <= '0;
      pend_off <= 1'b0;
      en_d     <= 1'b0;
      rail_release_first  <= 1'b0;
      rail_release_second <= 1'b0;
      rail_release_third  <= 1'b0;
      rail_oe_first       <= 1'b1;
      rail_oe_second      <= 1'b1;
      rail_oe_third       <= 1'b1;
    end else begin
      state    <= next_state;
      rails    <= next_rails;
      remain   <= next_remain;
      pend_off <= next_pend_off;
      en_d     <= en_s;
      rail_release_first  <= next_rails[0];
      rail_release_second <= next_rails[1];
      rail_release_third  <= next_rails[2];
      rail_oe_first       <= !next_rails[0];
      rail_oe_second      <= !next_rails[1];
      rail_oe_third       <= !next_rails[2];
    end
  end

  AST_RESET_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_OFF) |-> !rail_release_first && !rail_release_second && !rail_release_third)
    else $error("rails released while off");
  AST_UP_ORDER: assert property (@(posedge core_clk) disable iff (!rst_n)
    rail_release_second && state inside {ST_UP3, ST_ON} |-> rail_release_first)
    else $error("second released before first");
  AST_THIRD_AFTER_SECOND: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(rail_release_third) && state != ST_OFF |-> rail_release_second)
    else $error("third released out of order");
  AST_GLITCH: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_UP1 && !en_s) |=> state == ST_OFF && !rail_release_first)
    else $error("glitch did not reset timer");
  AST_FIRST_WAIT: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_UP1 && !expired) |=> !rail_release_first)
    else $error("first rail released early");
  AST_CTRL_SHUT: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_UP2 && en_fall) |=> state == ST_UP2 && pend_off)
    else $error("controlled shutdown not entered");
  AST_SETTLE: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(state == ST_SETTLE) |-> remain == TWIDTH'(SETTLE_TICKS))
    else $error("settle time wrong");
  AST_REFRESH: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == ST_ON && !en_s) |=> remain >= TWIDTH'(REFRESH_TICKS))
    else $error("refresh time missing");
  AST_OE: assert property (@(posedge core_clk) disable iff (!rst_n)
    rail_oe_first == !rail_release_first && rail_oe_second == !rail_release_second &&
    rail_oe_third == !rail_release_third)
    else $error("released rail still driven");
  AST_ORDER_LEGAL: assert property (@(posedge core_clk) disable iff (!rst_n)
    order <= 3'h5)
    else $error("illegal order code");

  COV_FULL_UP: cover property (@(posedge core_clk) disable iff (!rst_n) state == ST_ON);
  COV_SETTLE: cover property (@(posedge core_clk) disable iff (!rst_n) state == ST_SETTLE);
  COV_GLITCH: cover property (@(posedge core_clk) disable iff (!rst_n) state == ST_UP1 && !en_s);
endmodule

// File: hdl/tick_divider.sv
// Master time-base divider producing a one-cycle tick enable
`timescale 1ns/1ps
module tick_divider
  import rail_seq_pkg::*;
#(
  parameter int unsigned DIV = TICK_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  output logic      tick
);
  localparam int unsigned CW = $clog2(DIV + 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          next_tick;

  always_comb begin
    if (cnt == CW'(DIV - 1)) begin
      next_cnt  = '0;
      next_tick = 1'b1;
    end else begin
      next_cnt  = cnt + CW'(1);
      next_tick = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// File: tb/rail_load.sv
// Regulator enable inputs seen through pulled-up open-drain rail pins
`timescale 1ns/1ps
module rail_load (
  input  wire logic        rail_oe_first,
  input  wire logic        rail_oe_second,
  input  wire logic        rail_oe_third,
  output logic [2:0]       rail_lvl
);
  // Pull-up wins whenever the sequencer stops driving the pin low
  assign rail_lvl = {~rail_oe_third, ~rail_oe_second, ~rail_oe_first};
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the three-rail power sequencer
`timescale 1ns/1ps
module tb_top;
  import rail_seq_pkg::*;
  logic                 core_clk;
  logic                 rst_n;
  logic                 seq_enable;
  logic                 avs_read;
  logic                 avs_write;
  logic                 avs_waitrequest;
  logic [AV_ADDR_W-1:0] avs_address;
  logic [31:0]          avs_writedata;
  logic [31:0]          avs_readdata;
  logic [31:0]          rd;
  logic                 rel1;
  logic                 rel2;
  logic                 rel3;
  logic                 oe1;
  logic                 oe2;
  logic                 oe3;
  logic [2:0]           rail_lvl;
  logic [2:0]           prev;
  logic [5:0]           seq;
  // Order code in [10:8], expected lowering sequence of rails in [5:0]
  logic [11:0]          rows [6] = '{12'h039, 12'h136, 12'h22D, 12'h327, 12'h41E, 12'h51B};
  int                   bad_count;
  int                   tests_run;
  int                   n;
  int                   i;
  int                   k;

  rail_sequencer #(.TICK_DIV(1)) i_rail_sequencer (
    .core_clk(core_clk), .rst_n(rst_n), .seq_enable(seq_enable),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rail_release_first(rel1), .rail_release_second(rel2), .rail_release_third(rel3),
    .rail_oe_first(oe1), .rail_oe_second(oe2), .rail_oe_third(oe3)
  );

  rail_load i_rail_load (
    .rail_oe_first(oe1), .rail_oe_second(oe2), .rail_oe_third(oe3), .rail_lvl(rail_lvl)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task finish_test;
    if (bad_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task fail(input logic [31:0] g, input logic [31:0] e);
    bad_count++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
  endtask

  task chk32(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) fail(g, e);
  endtask

  task chk3(input logic [2:0] g, input logic [2:0] e);
    tests_run++;
    if (g !== e) fail({29'h0, g}, {29'h0, e});
  endtask

  task chkn(input int g, input int lo, input int hi);
    tests_run++;
    if (g < lo || g > hi) fail(g, lo);
  endtask

  // One Avalon transfer, held until waitrequest is seen low at an edge
  task av(input logic wr, input logic [AV_ADDR_W-1:0] a, input logic [31:0] d);
    logic done;
    int   c;
    done = 1'b0;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    for (c = 0; c < 50 && !done; c++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) begin
        done = 1'b1;
        rd = avs_readdata;
      end
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (!done) begin
      fail(32'h00000000, 32'h00000001);
      finish_test();
    end
  endtask

  task wlvl(input logic [2:0] e, input int lim);
    n = 0;
    while (rail_lvl !== e && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    if (rail_lvl !== e) begin
      fail({29'h0, rail_lvl}, {29'h0, e});
      finish_test();
    end
    chk3({rel3, rel2, rel1}, e);
  endtask

  task setl(input logic v);
    @(posedge core_clk);
    seq_enable <= v;
  endtask

  initial begin
    rst_n = 1'b0;
    seq_enable = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = 32'h00000000;
    bad_count = 0;
    tests_run = 0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk3(rail_lvl, 3'h0);
    av(1'b0, REG_UP_DELAYS, 32'h00000000); chk32(rd, 32'h00000FFF);
    av(1'b0, REG_DOWN_DELAYS, 32'h00000000); chk32(rd, 32'h00000FFF);
    av(1'b0, REG_CONFIG, 32'h00000000); chk32(rd, 32'h00000003);
    av(1'b0, 4'h2, 32'h00000000); chk32(rd, 32'h00000000);
    av(1'b0, REG_STATUS, 32'h00000000); chk32(rd, 32'h00000000);
    av(1'b1, REG_UP_DELAYS, 32'h00000000);
    av(1'b1, REG_DOWN_DELAYS, 32'h00000110);
    for (i = 0; i < 6; i++) begin
      av(1'b1, REG_CONFIG, {25'h0, rows[i][10:8], 4'h0});
      setl(1'b1);
      wlvl(3'h7, 3000); chk3(rail_lvl, 3'h7);
      setl(1'b0);
      seq = 6'h00;
      prev = 3'h7;
      for (k = 0; k < 10000 && rail_lvl !== 3'h0; k++) begin
        @(negedge core_clk);
        for (n = 0; n < 3; n++)
          if (prev[n] && !rail_lvl[n]) seq = {seq[3:0], 2'(n + 1)};
        prev = rail_lvl;
      end
      chk32({26'h0, seq}, {26'h0, rows[i][5:0]});
      repeat (20) @(negedge core_clk);
    end
    av(1'b1, REG_CONFIG, 32'h00000070);
    av(1'b0, REG_CONFIG, 32'h00000000); chk32(rd, 32'h00000050);
    av(1'b1, REG_CONFIG, 32'h00000000);
    av(1'b1, REG_UP_DELAYS, 32'h00000121);
    av(1'b1, REG_DOWN_DELAYS, 32'h00000210);
    av(1'b0, REG_UP_DELAYS, 32'h00000000); chk32(rd, 32'h00000121);
    // Short enable pulse must leave every rail low and restart timer one
    setl(1'b1);
    repeat (1000) @(negedge core_clk);
    setl(1'b0);
    repeat (3000) @(negedge core_clk);
    chk3(rail_lvl, 3'h0);
    setl(1'b1);
    wlvl(3'h1, 3000); chkn(n, 2400, 2410);
    wlvl(3'h3, 5000); chkn(n, 4000, 4008);
    wlvl(3'h7, 3000); chkn(n, 2000, 2008);
    setl(1'b0);
    wlvl(3'h3, 1000); chkn(n, 400, 410);
    wlvl(3'h1, 3000); chkn(n, 2000, 2008);
    wlvl(3'h0, 5000); chkn(n, 4000, 4008);
    repeat (20) @(negedge core_clk);
    // Drop in mid power-up: restarted timer, ups finish, no early fall
    setl(1'b1);
    wlvl(3'h1, 3000);
    repeat (500) @(negedge core_clk);
    setl(1'b0);
    wlvl(3'h3, 5000); chkn(n, 4000, 4010);
    wlvl(3'h7, 3000); chkn(n, 2000, 2008);
    repeat (5000) @(negedge core_clk);
    chk3(rail_lvl, 3'h7);
    av(1'b0, REG_STATUS, 32'h00000000); chk32(rd, {24'h000000, 1'b0, ST_SETTLE, 3'h7});
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk3(rail_lvl, 3'h0);
    av(1'b0, REG_CONFIG, 32'h00000000); chk32(rd, 32'h00000003);
    // Second column: 4 ms step for the second power-up delay
    av(1'b1, REG_UP_DELAYS, 32'h00000010);
    av(1'b1, REG_CONFIG, 32'h00000001);
    setl(1'b1);
    wlvl(3'h1, 1000); chkn(n, 400, 410);
    wlvl(3'h3, 5000); chkn(n, 4000, 4008);
    wlvl(3'h7, 100);
    finish_test();
  end
endmodule
